/* design/csa_pkg.sv */
package csa_pkg;
    // Credit count width: holds 0..256
    localparam int CRW          = 9;
    localparam int LIMIT_MIN    = 1;
    localparam int LIMIT_MAX    = 256;
    // Downstream side of the width converter takes a fixed credit limit
    localparam int N2W_DN_LIMIT = 32;
    // Credit limit of the credit-to-ready bridge's sending side
    localparam int C2R_LIMIT    = 16;
    localparam int RL_MAX       = 32;
    localparam int SYM_MAX      = 1024;
    localparam int CHW_MAX      = 128;
    localparam int ERRW_MAX     = 1024;
    localparam int SH_W         = 32;
    localparam int RST_VAL      = 0;

    // A width of zero means the field is absent; the port keeps one bit
    function automatic int csa_w(input int n);
        return (n < 1) ? 1 : n;
    endfunction

    function automatic bit csa_limit_ok(input int n);
        return (n >= LIMIT_MIN) && (n <= LIMIT_MAX) && ((n & (n - 1)) == 0);
    endfunction

    function automatic int csa_min(input int a, input int b);
        return (a < b) ? a : b;
    endfunction
endpackage

/* design/csa_top.sv */
`timescale 1ns/1ps
`default_nettype none
module csa_top import csa_pkg::*; #(
    parameter int NSYM         = 4,
    parameter int SYMW         = 8,
    parameter int RATIO        = 4,
    parameter int CHW          = 1,
    parameter int ERRW         = 1,
    parameter int EMPW         = 2,
    parameter int USRW         = 1,
    parameter bit USE_PKT      = 1'b1,
    parameter bit USE_EMPTY    = 1'b1,
    parameter bit USE_CHAN     = 1'b1,
    parameter bit USE_ERR      = 1'b1,
    parameter bit USE_USER     = 1'b1,
    parameter int N2W_UP_LIMIT = 8,
    parameter int MC_UP_LIMIT  = 4,
    parameter int MC_DN_LIMIT  = 8,
    parameter int R2C_LIMIT    = 16,
    parameter int R2C_RL       = 0,
    parameter int C2R_RL       = 0,
    parameter int PKW          = 32,
    parameter bit SYNC_RST     = 1'b0
) (
    input  wire logic                         sys_clk,
    input  wire logic                         resetn,
    input  wire logic                         n_in_valid,
    input  wire logic [NSYM*SYMW-1:0]         n_in_data,
    input  wire logic                         n_in_sop,
    input  wire logic                         n_in_eop,
    input  wire logic [csa_w(EMPW)-1:0]       n_in_empty,
    input  wire logic [CHW-1:0]               n_in_chan,
    input  wire logic [csa_w(ERRW)-1:0]       n_in_err,
    input  wire logic [USRW-1:0]              n_in_user,
    output var  logic                         n_up_crd_upd,
    output var  logic [CRW-1:0]               n_up_crd_cnt,
    input  wire logic                         n_dn_crd_upd,
    input  wire logic [CRW-1:0]               n_dn_crd_cnt,
    output var  logic                         n_out_valid,
    output var  logic [RATIO*NSYM*SYMW-1:0]   n_out_data,
    output var  logic                         n_out_sop,
    output var  logic                         n_out_eop,
    output var  logic [csa_w($clog2(RATIO*NSYM))-1:0] n_out_empty,
    output var  logic [CHW-1:0]               n_out_chan,
    output var  logic [csa_w(ERRW)-1:0]       n_out_err,
    output var  logic [USRW-1:0]              n_out_user,
    input  wire logic                         m_in_valid,
    input  wire logic [PKW-1:0]               m_in_pkt,
    output var  logic                         m_up_crd_upd,
    output var  logic [CRW-1:0]               m_up_crd_cnt,
    input  wire logic                         m_dn_crd_upd,
    input  wire logic [CRW-1:0]               m_dn_crd_cnt,
    output var  logic                         m_out_valid,
    output var  logic [PKW-1:0]               m_out_pkt,
    input  wire logic                         r_in_valid,
    input  wire logic [PKW-1:0]               r_in_pkt,
    output var  logic                         r_up_crd_upd,
    output var  logic [CRW-1:0]               r_up_crd_cnt,
    output var  logic                         r_out_valid,
    output var  logic [PKW-1:0]               r_out_pkt,
    input  wire logic                         r_out_ready,
    input  wire logic                         c_in_valid,
    input  wire logic [PKW-1:0]               c_in_pkt,
    output var  logic                         c_in_ready,
    input  wire logic                         c_dn_crd_upd,
    input  wire logic [CRW-1:0]               c_dn_crd_cnt,
    output var  logic                         c_out_valid,
    output var  logic [PKW-1:0]               c_out_pkt
);
    localparam int NB  = NSYM * SYMW;
    localparam int WB  = RATIO * NB;
    localparam int WEW = csa_w($clog2(RATIO * NSYM));
    localparam int ERW = csa_w(ERRW);
    localparam int BW  = $clog2(RATIO + 1);
    localparam int AW  = csa_w($clog2(R2C_LIMIT));
    localparam int RI  = (R2C_RL > 0) ? R2C_RL - 1 : 0;

    typedef struct packed {
        logic [CRW-1:0]              n_ucr;
        logic [CRW-1:0]              n_dcr;
        logic [BW-1:0]               n_cnt;
        logic                        n_done;
        logic [WB-1:0]               n_asm;
        logic                        n_sop;
        logic                        n_eop;
        logic [WEW-1:0]              n_emp;
        logic [CHW-1:0]              n_ch;
        logic [ERW-1:0]              n_er;
        logic [USRW-1:0]             n_us;
        logic                        n_cu;
        logic [CRW-1:0]              n_cc;
        logic                        n_ov;
        logic [CRW-1:0]              m_bank;
        logic [CRW-1:0]              m_out;
        logic                        m_cu;
        logic [CRW-1:0]              m_cc;
        logic                        m_ov;
        logic [PKW-1:0]              m_pk;
        logic [R2C_LIMIT-1:0][PKW-1:0] r_mem;
        logic [AW-1:0]               r_wp;
        logic [AW-1:0]               r_rp;
        logic [CRW-1:0]              r_cnt;
        logic [CRW-1:0]              r_out;
        logic                        r_cu;
        logic [CRW-1:0]              r_cc;
        logic                        r_ov;
        logic [PKW-1:0]              r_pk;
        logic [SH_W-1:0]             r_sh;
        logic [CRW-1:0]              c_cred;
        logic                        c_rdy;
        logic [SH_W-1:0]             c_sh;
        logic                        c_ov;
        logic [PKW-1:0]              c_pk;
    } csa_state_t;

    csa_state_t q;
    csa_state_t d;

    function automatic logic [AW-1:0] csa_inc(input logic [AW-1:0] p);
        return (int'(p) == R2C_LIMIT - 1) ? '0 : AW'(int'(p) + 1);
    endfunction

    logic [SH_W:0] r_vec;
    logic [SH_W:0] c_vec;
    assign r_vec = {q.r_sh, r_out_ready};
    assign c_vec = {q.c_sh, q.c_rdy};

    always_comb begin
        int slot;
        int t;
        int g;
        logic first;
        slot  = 0;
        t     = 0;
        g     = 0;
        first = 1'b0;
        d     = q;
        // Width converter; one upstream credit at a time keeps the assembly from overrunning
        d.n_ov = 1'b0;
        d.n_cu = 1'b0;
        if (q.n_done && q.n_dcr != '0) begin
            d.n_ov   = 1'b1;
            d.n_done = 1'b0;
            d.n_cnt  = '0;
        end
        t = int'(q.n_dcr) - int'(d.n_ov) + (n_dn_crd_upd ? int'(n_dn_crd_cnt) : 0);
        d.n_dcr = CRW'(csa_min(t, N2W_DN_LIMIT));
        if (n_in_valid) begin
            slot  = RATIO - 1 - int'(q.n_cnt);
            first = (q.n_cnt == '0);
            if (first) begin
                d.n_asm = '0;
                d.n_sop = USE_PKT & n_in_sop;
                d.n_ch  = USE_CHAN ? n_in_chan : '0;
                d.n_us  = USE_USER ? n_in_user : '0;
            end
            d.n_asm[slot*NB +: NB] = n_in_data;
            d.n_er  = (first ? '0 : q.n_er) | ((USE_ERR && ERRW > 0) ? n_in_err : '0);
            d.n_cnt = BW'(int'(q.n_cnt) + 1);
            d.n_eop = USE_PKT & n_in_eop;
            d.n_emp = '0;
            if (int'(q.n_cnt) == RATIO - 1 || (USE_PKT && n_in_eop)) begin
                d.n_done = 1'b1;
                if (USE_PKT && USE_EMPTY && EMPW > 0) begin
                    d.n_emp = WEW'(slot * NSYM + int'(n_in_empty));
                end
            end
        end
        d.n_ucr = q.n_ucr - CRW'(n_in_valid);
        if (d.n_ucr == '0 && !d.n_done) begin
            d.n_cu  = 1'b1;
            d.n_cc  = CRW'(1);
            d.n_ucr = CRW'(1);
        end
        // Credit limit adapter: bank downstream credits, dole them out upstream
        d.m_ov = m_in_valid;
        d.m_pk = m_in_pkt;
        d.m_cu = 1'b0;
        t = csa_min(int'(q.m_bank) + (m_dn_crd_upd ? int'(m_dn_crd_cnt) : 0), MC_DN_LIMIT);
        g = csa_min(MC_UP_LIMIT - (int'(q.m_out) - int'(m_in_valid)), t);
        if (g > 0) begin
            d.m_cu = 1'b1;
            d.m_cc = CRW'(g);
        end
        d.m_bank = CRW'(t - g);
        d.m_out  = CRW'(int'(q.m_out) - int'(m_in_valid) + g);
        // Ready bridge: credits advertise free buffer slots
        d.r_sh = {q.r_sh[SH_W-2:0], r_out_ready};
        d.r_cu = 1'b0;
        if (R2C_RL == 0) begin
            d.r_ov = q.r_ov && !r_out_ready;
        end else begin
            d.r_ov = 1'b0;
        end
        if (q.r_cnt != '0 && ((R2C_RL == 0) ? !d.r_ov : r_vec[RI])) begin
            d.r_ov  = 1'b1;
            d.r_pk  = q.r_mem[q.r_rp];
            d.r_rp  = csa_inc(q.r_rp);
            d.r_cnt = d.r_cnt - CRW'(1);
        end
        if (r_in_valid) begin
            d.r_mem[q.r_wp] = r_in_pkt;
            d.r_wp  = csa_inc(q.r_wp);
            d.r_cnt = d.r_cnt + CRW'(1);
            d.r_out = q.r_out - CRW'(1);
        end
        g = R2C_LIMIT - int'(d.r_cnt) - int'(d.r_out);
        if (g > 0) begin
            d.r_cu  = 1'b1;
            d.r_cc  = CRW'(g);
            d.r_out = CRW'(int'(d.r_out) + g);
        end
        // Credit bridge: each ready cycle reserves a credit, returned if no beat follows
        d.c_sh = {q.c_sh[SH_W-2:0], q.c_rdy};
        d.c_ov = c_vec[C2R_RL] && c_in_valid;
        d.c_pk = c_in_pkt;
        t = int'(q.c_cred) + (c_dn_crd_upd ? int'(c_dn_crd_cnt) : 0) + int'(c_vec[C2R_RL] && !c_in_valid);
        t = csa_min(t, C2R_LIMIT);
        d.c_rdy  = (t > 0);
        d.c_cred = CRW'(t - int'(d.c_rdy));
        if (SYNC_RST && !resetn) begin
            d = '0;
        end
    end

    generate
        if (SYNC_RST) begin : g_sync
            always_ff @(posedge sys_clk) begin
                q <= d;
            end
        end else begin : g_async
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    q <= csa_state_t'(RST_VAL);
                end else begin
                    q <= d;
                end
            end
        end
    endgenerate

    assign n_up_crd_upd = q.n_cu;
    assign n_up_crd_cnt = q.n_cc;
    assign n_out_valid  = q.n_ov;
    assign n_out_data   = q.n_asm;
    assign n_out_sop    = q.n_sop;
    assign n_out_eop    = q.n_eop;
    assign n_out_empty  = q.n_emp;
    assign n_out_chan   = q.n_ch;
    assign n_out_err    = q.n_er;
    assign n_out_user   = q.n_us;
    assign m_up_crd_upd = q.m_cu;
    assign m_up_crd_cnt = q.m_cc;
    assign m_out_valid  = q.m_ov;
    assign m_out_pkt    = q.m_pk;
    assign r_up_crd_upd = q.r_cu;
    assign r_up_crd_cnt = q.r_cc;
    assign r_out_valid  = q.r_ov;
    assign r_out_pkt    = q.r_pk;
    assign c_in_ready   = q.c_rdy;
    assign c_out_valid  = q.c_ov;
    assign c_out_pkt    = q.c_pk;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_n2w_dn_cap: assert property (int'(q.n_dcr) <= N2W_DN_LIMIT)
        else $error("converter downstream credits above limit");
    a_n2w_send_ok: assert property (n_out_valid |-> $past(q.n_done) && $past(q.n_dcr) != '0)
        else $error("wide beat sent without credit or data");
    a_n2w_hold: assert property (q.n_done && q.n_dcr == '0 && !n_dn_crd_upd |=> !n_out_valid)
        else $error("wide beat sent with no credit");
    a_n2w_up_cap: assert property (int'(q.n_ucr) <= N2W_UP_LIMIT)
        else $error("converter upstream credits above limit");
    a_mc_out_cap: assert property (int'(q.m_out) <= MC_UP_LIMIT)
        else $error("limit adapter exceeds upstream limit");
    a_mc_release: assert property (m_in_valid && q.m_bank != '0 |=> m_up_crd_upd)
        else $error("banked credit not released");
    a_mc_pass: assert property (m_in_valid |=> m_out_valid && m_out_pkt == $past(m_in_pkt))
        else $error("limit adapter altered beat");
    a_r2c_delay: assert property (R2C_RL > 0 && r_out_valid |-> r_vec[R2C_RL])
        else $error("valid outside ready window");
    a_c2r_cap: assert property (int'(q.c_cred) <= C2R_LIMIT)
        else $error("credit bridge credits above limit");
    a_limit_legal: assert property (csa_limit_ok(MC_UP_LIMIT) && csa_limit_ok(R2C_LIMIT) &&
        csa_limit_ok(MC_DN_LIMIT) && csa_limit_ok(N2W_UP_LIMIT))
        else $error("credit limit not a legal power of two");
    a_mc_lim_order: assert property (MC_UP_LIMIT < MC_DN_LIMIT)
        else $error("limit adapter upstream limit not below downstream");
    a_sym_range: assert property (NSYM >= 1 && NSYM <= SYM_MAX && SYMW >= 1 && SYMW <= SYM_MAX)
        else $error("symbol count or width out of range");
    a_side_range: assert property (CHW >= 1 && CHW <= CHW_MAX && ERRW <= ERRW_MAX &&
        R2C_RL <= RL_MAX && C2R_RL <= RL_MAX)
        else $error("sideband width or ready delay out of range");

    c_n2w_pkt: cover property (n_out_valid && n_out_eop);
    c_mc_grant: cover property (m_in_valid ##1 m_up_crd_upd);
    c_r2c_beat: cover property (r_out_valid && r_out_ready);
    c_c2r_beat: cover property (c_in_ready ##1 c_out_valid);
endmodule // csa_top
`default_nettype wire

/* tb/csa_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module csa_far_model import csa_pkg::*; (
    input  wire logic           sys_clk,
    output var  logic           n_dn_crd_upd,
    output var  logic [CRW-1:0] n_dn_crd_cnt,
    output var  logic           m_dn_crd_upd,
    output var  logic [CRW-1:0] m_dn_crd_cnt,
    output var  logic           c_dn_crd_upd,
    output var  logic [CRW-1:0] c_dn_crd_cnt,
    output var  logic           r_out_ready
);
    logic slow = 1'b0;
    initial begin
        {n_dn_crd_upd, m_dn_crd_upd, c_dn_crd_upd} = 3'h0;
        {n_dn_crd_cnt, m_dn_crd_cnt, c_dn_crd_cnt} = 27'h0;
        r_out_ready = 1'b1;
    end
    // A busy receiver drops ready at random in slow mode
    always @(negedge sys_clk) begin
        r_out_ready <= slow ? 1'($urandom % 2) : 1'b1;
    end
    // Credits go out only when asked, as a receiver with free room would send them
    task automatic grant(input int which, input logic [CRW-1:0] cnt);
        @(negedge sys_clk);
        {n_dn_crd_upd, m_dn_crd_upd, c_dn_crd_upd} = {which == 0, which == 1, which == 2};
        {n_dn_crd_cnt, m_dn_crd_cnt, c_dn_crd_cnt} = {3{cnt}};
        @(negedge sys_clk);
        {n_dn_crd_upd, m_dn_crd_upd, c_dn_crd_upd} = 3'h0;
        // The count means nothing outside a pulse, so it never keeps the last value
        {n_dn_crd_cnt, m_dn_crd_cnt, c_dn_crd_cnt} = {3{~cnt}};
    endtask
endmodule // csa_far_model
`default_nettype wire

/* tb/csa_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module csa_tb_top import csa_pkg::*;;
    logic         sys_clk = 1'b0, resetn = 1'b0;
    logic         n_in_valid, n_in_sop, n_in_eop, n_in_chan, n_in_err, n_in_user;
    logic [31:0]  n_in_data, m_in_pkt, r_in_pkt, c_in_pkt, m_out_pkt, r_out_pkt, c_out_pkt;
    logic [1:0]   n_in_empty;
    logic [3:0]   n_out_empty;
    logic [127:0] n_out_data, acc;
    logic [8:0]   n_up_crd_cnt, n_dn_crd_cnt, m_up_crd_cnt, m_dn_crd_cnt, r_up_crd_cnt, c_dn_crd_cnt;
    logic         n_up_crd_upd, n_dn_crd_upd, n_out_valid, n_out_sop, n_out_eop, n_out_chan, n_out_err;
    logic         n_out_user, m_in_valid, m_up_crd_upd, m_dn_crd_upd, m_out_valid, r_in_valid;
    logic         r_up_crd_upd, r_out_valid, r_out_ready, c_in_valid, c_in_ready, c_dn_crd_upd, c_out_valid;
    logic         fsop, fch, fus, aerr;
    logic [136:0] n_got[$], n_exp[$], m_got[$], m_exp[$], r_got[$], r_exp[$], c_got[$], c_exp[$];
    int           n_fail = 0, num_checks = 0, n_cr = 0, m_cr = 0, m_tot = 0, r_cr = 0, k = 0, len;

    always #10 sys_clk = ~sys_clk;

    // Wide word is up to four narrow beats; an end of packet closes it early
    csa_top DUT (.sys_clk, .resetn, .n_in_valid, .n_in_data, .n_in_sop, .n_in_eop, .n_in_empty, .n_in_chan,
        .n_in_err, .n_in_user, .n_up_crd_upd, .n_up_crd_cnt, .n_dn_crd_upd, .n_dn_crd_cnt, .n_out_valid,
        .n_out_data, .n_out_sop, .n_out_eop, .n_out_empty, .n_out_chan, .n_out_err, .n_out_user, .m_in_valid,
        .m_in_pkt, .m_up_crd_upd, .m_up_crd_cnt, .m_dn_crd_upd, .m_dn_crd_cnt, .m_out_valid, .m_out_pkt,
        .r_in_valid, .r_in_pkt, .r_up_crd_upd, .r_up_crd_cnt, .r_out_valid, .r_out_pkt, .r_out_ready,
        .c_in_valid, .c_in_pkt, .c_in_ready, .c_dn_crd_upd, .c_dn_crd_cnt, .c_out_valid, .c_out_pkt);

    csa_far_model far (.sys_clk, .n_dn_crd_upd, .n_dn_crd_cnt, .m_dn_crd_upd, .m_dn_crd_cnt,
        .c_dn_crd_upd, .c_dn_crd_cnt, .r_out_ready);

    task automatic check(input logic [136:0] seen, input logic [136:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask

    task automatic cmpq(ref logic [136:0] g[$], ref logic [136:0] e[$]);
        check(137'(g.size()), 137'(e.size()));
        foreach (e[i])
            if (i < g.size())
                check(g[i], e[i]);
    endtask

    task automatic finish_test;
        if (n_fail == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Registered outputs are read at the edge, before that edge's updates land
    always @(posedge sys_clk) begin
        if (n_up_crd_upd) begin
            n_cr += n_up_crd_cnt;
            check(137'(n_up_crd_cnt), 137'h1);
        end
        if (m_up_crd_upd) begin
            m_cr += m_up_crd_cnt;
            m_tot += m_up_crd_cnt;
            check(137'(m_cr <= 4), 137'h1);
        end
        if (r_up_crd_upd) begin
            r_cr += r_up_crd_cnt;
            check(137'(r_cr <= 16), 137'h1);
        end
        if (n_out_valid)
            n_got.push_back({n_out_data, n_out_sop, n_out_eop, n_out_empty, n_out_chan, n_out_err, n_out_user});
        if (m_out_valid)
            m_got.push_back(137'(m_out_pkt));
        if (r_out_valid && r_out_ready)
            r_got.push_back(137'(r_out_pkt));
        if (c_out_valid)
            c_got.push_back(137'(c_out_pkt));
    end

    task automatic n_beat(input logic s, input logic e);
        logic [31:0] d;
        logic [2:0]  sb;
        logic [1:0]  emp;
        int          w;
        d = $urandom;
        sb = 3'($urandom);
        emp = e ? 2'($urandom) : 2'h0;
        w = 0;
        @(negedge sys_clk);
        while (n_cr == 0 && w++ < 50)
            @(negedge sys_clk);
        check(137'(n_cr > 0), 137'h1);
        n_cr--;
        {n_in_valid, n_in_data, n_in_sop, n_in_eop, n_in_empty} = {1'b1, d, s, e, emp};
        {n_in_chan, n_in_err, n_in_user} = sb;
        if (k == 0) begin
            {acc, aerr} = '0;
            {fsop, fch, fus} = {s, sb[2], sb[0]};
        end
        acc[(3 - k) * 32 +: 32] = d;
        aerr |= sb[1];
        k++;
        if (e || k == 4) begin
            n_exp.push_back({acc, fsop, e, 4'((4 - k) * 4 + emp), fch, aerr, fus});
            k = 0;
        end
        @(negedge sys_clk);
        n_in_valid = 1'b0;
    endtask

    // One beat on the limit adapter (0) or the ready bridge (1), sent once a credit is held or after 50 cycles of waiting without one
    task automatic pk_beat(input bit which);
        logic [31:0] d;
        int          w;
        d = $urandom;
        w = 0;
        @(negedge sys_clk);
        while ((which ? r_cr : m_cr) == 0 && w++ < 50)
            @(negedge sys_clk);
        check(137'((which ? r_cr : m_cr) > 0), 137'h1);
        if (which) begin
            r_cr--;
            {r_in_valid, r_in_pkt} = {1'b1, d};
            r_exp.push_back(137'(d));
        end else begin
            m_cr--;
            {m_in_valid, m_in_pkt} = {1'b1, d};
            m_exp.push_back(137'(d));
        end
        @(negedge sys_clk);
        {m_in_valid, r_in_valid} = 2'h0;
    endtask

    initial begin
        void'($urandom(26319));
        {n_in_valid, n_in_sop, n_in_eop, n_in_chan, n_in_err, n_in_user, n_in_empty, n_in_data} = '0;
        {m_in_valid, m_in_pkt, r_in_valid, r_in_pkt, c_in_valid, c_in_pkt} = '0;
        repeat (2) @(negedge sys_clk);
        check(137'({n_out_valid, m_out_valid, r_out_valid, c_out_valid, c_in_ready}), 137'h0);
        repeat (2) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (3) @(negedge sys_clk);
        check(137'(n_cr), 137'h1);
        check(137'(r_cr), 137'h10);
        far.grant(0, 9'h028);
        repeat (33) begin
            len = 1 + $urandom % 4;
            fch = 1'($urandom);
            for (int b = 0; b < len; b++)
                n_beat(b == 0, b == len - 1 && (len < 4 || fch));
        end
        repeat (8) @(negedge sys_clk);
        check(137'(n_got.size()), 137'h20);
        far.grant(0, 9'h001);
        repeat (8) @(negedge sys_clk);
        cmpq(n_got, n_exp);
        far.grant(1, 9'h008);
        repeat (8) pk_beat(0);
        repeat (4) @(negedge sys_clk);
        check(137'(m_tot), 137'h8);
        cmpq(m_got, m_exp);
        far.slow = 1'b1;
        repeat (20) pk_beat(1);
        repeat (60) @(negedge sys_clk);
        cmpq(r_got, r_exp);
        far.grant(2, 9'h003);
        repeat (20) begin
            @(negedge sys_clk);
            {c_in_valid, c_in_pkt} = {c_in_ready, 32'($urandom)};
            if (c_in_ready)
                c_exp.push_back(137'(c_in_pkt));
        end
        c_in_valid = 1'b0;
        repeat (4) @(negedge sys_clk);
        check(137'(c_exp.size()), 137'h3);
        check(137'(c_in_ready), 137'h0);
        cmpq(c_got, c_exp);
        finish_test;
    end

    initial begin
        #200000;
        n_fail++;
        finish_test;
    end
endmodule // csa_tb_top
`default_nettype wire
